//--- design/va_decode_pkg.sv
// Constants, types and option tables for the virtual address front end.
// Assumes a single core clock domain; no software-visible registers.
package va_decode_pkg;

  localparam int VA_BITS = 64;
  localparam int MIN_VA_WIDTH = 43;
  localparam int FRAME_BITS = 32;
  localparam int PAGE_OPT_BITS = 2;
  localparam int MAX_PA_BITS = 48;
  localparam logic [1:0] PAGE_8K = 2'h0;
  localparam logic [1:0] PAGE_16K = 2'h1;
  localparam logic [1:0] PAGE_32K = 2'h2;
  localparam logic [1:0] PAGE_64K = 2'h3;
  localparam int OFFSET_BITS_MIN = 13;
  localparam int LEVEL_BITS_MIN = 10;
  localparam int LEVEL_COUNT = 3;
  localparam int PA_BITS_8K = 41;
  localparam int PA_BITS_16K = 45;
  localparam int PA_BITS_32K = 47;
  localparam int PA_BITS_64K = 48;
  // Table word field positions
  localparam int WORD_FRAME_LSB = 32;
  localparam int WORD_VALID = 0;
  localparam int WORD_FOR = 1;
  localparam int WORD_FOW = 2;
  localparam int WORD_FOE = 3;
  localparam int WORD_KRE = 8;
  localparam int WORD_URE = 9;
  localparam int WORD_KWE = 12;
  localparam int WORD_UWE = 13;
  localparam logic [1:0] SEG_DIRECT = 2'h2;
  localparam logic [1:0] SEG_HIGH = 2'h3;

  typedef enum logic [1:0] {ACC_LOAD, ACC_STORE, ACC_FETCH} access_t;
  typedef enum logic [1:0] {REGION_LOW, REGION_HIGH, REGION_DIRECT, REGION_NONE} region_t;

  function automatic int offset_bits(input logic [1:0] opt);
    return OFFSET_BITS_MIN + int'(opt);
  endfunction

  function automatic int va_width(input logic [1:0] opt);
    return offset_bits(opt) + LEVEL_COUNT * (LEVEL_BITS_MIN + int'(opt));
  endfunction

  function automatic int pa_width(input logic [1:0] opt);
    int w;
    w = PA_BITS_8K;
    case (opt)
      PAGE_16K: w = PA_BITS_16K;
      PAGE_32K: w = PA_BITS_32K;
      PAGE_64K: w = PA_BITS_64K;
      default: w = PA_BITS_8K;
    endcase
    return w;
  endfunction

endpackage

//--- design/page_protect.sv
// Per-page protection check against a translation word.
// Assumes the word comes from the translation buffer in the same cycle.
`timescale 1ns/1ps
module page_protect
  import va_decode_pkg::*;
(
  input wire logic [63:0] table_word,
  input wire access_t access,
  input wire logic user_mode,
  output logic violation,
  output logic read_fault,
  output logic write_fault,
  output logic exec_fault,
  output logic not_valid
);

  wire is_write = (access == ACC_STORE);
  wire read_ok = user_mode ? table_word[WORD_URE] : table_word[WORD_KRE];
  wire write_ok = user_mode ? table_word[WORD_UWE] : table_word[WORD_KWE];

  // Per mode: independent read and write enables; fault bits limit data or instruction use
  assign violation = is_write ? !write_ok : !read_ok;
  assign not_valid = !violation && !table_word[WORD_VALID];
  assign read_fault = !violation && !not_valid && (access == ACC_LOAD) && table_word[WORD_FOR];
  assign write_fault = !violation && !not_valid && is_write && table_word[WORD_FOW];
  assign exec_fault = !violation && !not_valid && (access == ACC_FETCH) && table_word[WORD_FOE];

endmodule

//--- design/va_segment_decode.sv
// Virtual address front end: range check, region select, direct relocation, protection.
// Assumes the core presents one request per cycle with a translation word already looked up.
`timescale 1ns/1ps
module va_segment_decode
  import va_decode_pkg::*;
#(
  parameter logic [1:0] PAGE_OPTION = PAGE_8K,
  parameter int PA_IMPL_BITS = 41
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [63:0] virt_addr,
  input wire access_t access,
  input wire logic user_mode,
  input wire logic firmware_mode,
  input wire logic firmware_fetch_unmapped,
  input wire logic [63:0] table_word,
  output logic req_ready,
  output logic rsp_valid,
  output region_t region,
  output logic [63:0] phys_addr,
  output logic [1:0] space_type,
  output logic access_violation,
  output logic translation_not_valid,
  output logic fault_on_read,
  output logic fault_on_write,
  output logic fault_on_execute,
  output logic needs_lookup,
  output logic [15:0] level_index_0,
  output logic [15:0] level_index_1,
  output logic [15:0] level_index_2,
  output logic [15:0] page_offset_field
);

  ////////////////////////////////////////////////////////////////////////////////
  // Option derived widths
  localparam int OFF_W = offset_bits(PAGE_OPTION);
  localparam int LVL_W = LEVEL_BITS_MIN + int'(PAGE_OPTION);
  localparam int VA_W = va_width(PAGE_OPTION);
  localparam int PA_MAX = pa_width(PAGE_OPTION);
  localparam int PA_W = (PA_IMPL_BITS < PA_MAX) ? PA_IMPL_BITS : PA_MAX;
  localparam logic [63:0] PA_MASK = (64'h1 << PA_W) - 64'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Range check and region select
  wire sign_bit = virt_addr[VA_W-1];
  wire [63:0] upper_ref = {64{sign_bit}} << VA_W;
  wire [63:0] upper_got = virt_addr & ({64{1'b1}} << VA_W);
  wire in_range = (upper_got == upper_ref);
  wire [1:0] seg_bits = virt_addr[VA_W-1 -: 2];
  wire is_direct = (seg_bits == SEG_DIRECT);
  wire is_high = (seg_bits == SEG_HIGH);
  // Firmware may run fetches unmapped; translation otherwise applies to every in-range address outside the direct region
  wire fetch_unmapped = firmware_mode && firmware_fetch_unmapped && (access == ACC_FETCH);

  ////////////////////////////////////////////////////////////////////////////////
  // Direct region relocation
  wire [63:0] low_bits = virt_addr & ((64'h1 << (VA_W - 2)) - 64'h1);
  wire [63:0] direct_pa = virt_addr[VA_W-3] ? (low_bits | ({64{1'b1}} << (VA_W - 2))) : low_bits;
  wire direct_violation = user_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Mapped translation
  wire [FRAME_BITS-1:0] frame = table_word[WORD_FRAME_LSB +: FRAME_BITS];
  wire [63:0] frame_wide = {32'h0, frame};
  wire [63:0] offset_part = virt_addr & ((64'h1 << OFF_W) - 64'h1);
  wire [63:0] mapped_pa = (frame_wide << OFF_W) | offset_part;
  wire page_violation;
  wire page_not_valid;
  wire page_for;
  wire page_fow;
  wire page_foe;

  page_protect u_protect (
    .table_word(table_word),
    .access(access),
    .user_mode(user_mode),
    .violation(page_violation),
    .read_fault(page_for),
    .write_fault(page_fow),
    .exec_fault(page_foe),
    .not_valid(page_not_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Combined decision
  wire use_direct = fetch_unmapped || is_direct;
  wire [63:0] raw_pa = fetch_unmapped ? virt_addr : (use_direct ? direct_pa : mapped_pa);
  wire [63:0] next_phys = raw_pa & PA_MASK;
  wire next_acv = !in_range || (is_direct && !fetch_unmapped && direct_violation)
                  || (!use_direct && page_violation);
  wire mapped_ok = in_range && !use_direct;
  region_t next_region;
  assign next_region = !in_range ? REGION_NONE : (is_direct ? REGION_DIRECT : (is_high ? REGION_HIGH : REGION_LOW));

  // Single-cycle path; never stalls
  assign req_ready = 1'b1;

  // Level index fields for the walker / buffer lookup, lowest level first
  wire [15:0] level_field [LEVEL_COUNT];
  for (genvar lv = 0; lv < LEVEL_COUNT; lv++)
  begin : gen_level
    wire [63:0] level_shift = virt_addr >> (OFF_W + lv * LVL_W);
    assign level_field[lv] = level_shift[15:0] & ((16'h1 << LVL_W) - 16'h1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result registers, visible the cycle after acceptance edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      region <= REGION_NONE;
      phys_addr <= 64'h0;
      space_type <= 2'h0;
      access_violation <= 1'b0;
      translation_not_valid <= 1'b0;
      fault_on_read <= 1'b0;
      fault_on_write <= 1'b0;
      fault_on_execute <= 1'b0;
      needs_lookup <= 1'b0;
      level_index_0 <= 16'h0;
      level_index_1 <= 16'h0;
      level_index_2 <= 16'h0;
      page_offset_field <= 16'h0;
    end
    else
    begin
      rsp_valid <= req_valid;
      if (req_valid)
      begin
        region <= next_region;
        phys_addr <= next_acv ? 64'h0 : next_phys;
        space_type <= next_phys[PA_W-1 -: 2];
        access_violation <= next_acv;
        translation_not_valid <= mapped_ok && !page_violation && page_not_valid;
        fault_on_read <= mapped_ok && page_for;
        fault_on_write <= mapped_ok && page_fow;
        fault_on_execute <= mapped_ok && page_foe;
        needs_lookup <= mapped_ok;
        level_index_0 <= level_field[0];
        level_index_1 <= level_field[1];
        level_index_2 <= level_field[2];
        page_offset_field <= offset_part[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  range_fault_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && !in_range |=> access_violation && rsp_valid && region == REGION_NONE)
    else $error("out of range address did not fault");

  range_sign_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && (virt_addr[63:VA_W-1] == '0) |=> region != REGION_NONE)
    else $error("positive in range address rejected");

  direct_sel_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && in_range && seg_bits == SEG_DIRECT |=> region == REGION_DIRECT && !needs_lookup)
    else $error("direct region not selected");

  direct_user_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && in_range && is_direct && user_mode && !fetch_unmapped |=> access_violation)
    else $error("user access to direct region allowed");

  direct_reloc_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && in_range && is_direct && !user_mode && !fetch_unmapped
    |=> phys_addr == ($past(direct_pa) & PA_MASK))
    else $error("direct relocation wrong");

  mapped_pa_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && mapped_ok && !page_violation
    |=> phys_addr[OFF_W-1:0] == $past(virt_addr[OFF_W-1:0])
        && phys_addr[PA_W-1:OFF_W] == $past(table_word[WORD_FRAME_LSB +: PA_W - OFF_W]))
    else $error("frame number not placed above offset");

  store_write_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && mapped_ok && access == ACC_STORE && !table_word[user_mode ? WORD_UWE : WORD_KWE]
    |=> access_violation)
    else $error("store without write enable allowed");

  pa_width_a: assert property (@(posedge clk) disable iff (rst)
    rsp_valid |-> (phys_addr >> PA_W) == 64'h0)
    else $error("physical address wider than implemented");

  same_cycle_a: assert property (@(posedge clk) disable iff (rst)
    req_valid |-> req_ready ##1 rsp_valid)
    else $error("response not presented on time");

  offset_keep_a: assert property (@(posedge clk) disable iff (rst)
    req_valid
    |=> page_offset_field == 16'($past(virt_addr[OFF_W-1:0])))
    else $error("page offset field wrong");

  level_split_a: assert property (@(posedge clk) disable iff (rst)
    req_valid
    |=> {level_index_2[LVL_W-1:0], level_index_1[LVL_W-1:0], level_index_0[LVL_W-1:0],
      page_offset_field[OFF_W-1:0]} == $past(virt_addr[VA_W-1:0]))
    else $error("level fields do not tile the address");

  level_upper_a: assert property (@(posedge clk) disable iff (rst)
    req_valid
    |=> (level_index_0 >> LVL_W) == 16'h0 && (level_index_1 >> LVL_W) == 16'h0
        && (level_index_2 >> LVL_W) == 16'h0)
    else $error("level field wider than level width");

  frame_width_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && mapped_ok && !page_violation
    |=> (phys_addr >> (OFF_W + FRAME_BITS)) == 64'h0)
    else $error("frame number wider than its field");

  pa_table_a: assert property (@(posedge clk) disable iff (rst)
    rsp_valid |-> (phys_addr >> PA_MAX) == 64'h0)
    else $error("physical address beyond page option limit");

  pa_reach_a: assert property (@(posedge clk) disable iff (rst)
    rsp_valid |-> (phys_addr >> (VA_W - 2)) == 64'h0)
    else $error("physical address not reachable through direct region");

  space_bits_a: assert property (@(posedge clk) disable iff (rst)
    rsp_valid && !access_violation |-> space_type == phys_addr[PA_W-1 -: 2])
    else $error("space type not top physical bits");

  unmapped_fetch_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && in_range && firmware_mode && firmware_fetch_unmapped && access == ACC_FETCH
    |=> !access_violation && !needs_lookup && phys_addr == ($past(virt_addr) & PA_MASK))
    else $error("firmware fetch not passed unmapped");

  always_mapped_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && in_range && seg_bits != SEG_DIRECT
    && !(firmware_mode && firmware_fetch_unmapped && access == ACC_FETCH)
    |=> needs_lookup)
    else $error("mapped address skipped translation");

  load_read_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && mapped_ok && access != ACC_STORE && !table_word[user_mode ? WORD_URE : WORD_KRE]
    |=> access_violation)
    else $error("read without read enable allowed");

  invalid_word_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && mapped_ok && !page_violation && !table_word[WORD_VALID]
    |=> translation_not_valid && !fault_on_read && !fault_on_write && !fault_on_execute)
    else $error("invalid word not reported");

  fetch_fault_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && mapped_ok && !page_violation && table_word[WORD_VALID]
    && access == ACC_FETCH && table_word[WORD_FOE]
    |=> fault_on_execute && !access_violation)
    else $error("data only page allowed a fetch");

  read_fault_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && mapped_ok && !page_violation && table_word[WORD_VALID]
    && access == ACC_LOAD && table_word[WORD_FOR]
    |=> fault_on_read && !access_violation)
    else $error("instruction only page allowed a load");

  direct_kernel_a: assert property (@(posedge clk) disable iff (rst)
    req_valid && in_range && is_direct && !user_mode
    |=> !access_violation && region == REGION_DIRECT)
    else $error("kernel access to direct region refused");

  acv_zero_a: assert property (@(posedge clk) disable iff (rst)
    rsp_valid && access_violation |-> phys_addr == 64'h0)
    else $error("faulting access leaked an address");

endmodule

//--- test/core_req_model.sv
// Core-side request source for the virtual address front end.
// Assumes one core clock; requests change 1 ns after the rising edge.
`timescale 1ns/1ps
module core_req_model
  import va_decode_pkg::*;
(
  input wire logic clk,
  output logic req_valid,
  output logic [63:0] virt_addr,
  output access_t access,
  output logic user_mode,
  output logic firmware_mode,
  output logic firmware_fetch_unmapped,
  output logic [63:0] table_word
);
  initial
  begin
    req_valid = 1'b0;
    virt_addr = 64'h0;
    access = ACC_LOAD;
    user_mode = 1'b0;
    firmware_mode = 1'b0;
    firmware_fetch_unmapped = 1'b0;
    table_word = 64'h0;
  end
  // One request per call, taken at the next edge; back to back calls fill every cycle
  task automatic send(input logic [63:0] va, input access_t a, input logic um, input logic [1:0] fw,
    input logic [63:0] tw);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    virt_addr = va;
    access = a;
    user_mode = um;
    firmware_mode = fw[1];
    firmware_fetch_unmapped = fw[0];
    table_word = tw;
  endtask
  // Released address and table word lines show the inverse of their last value; access and mode lines keep theirs
  task automatic idle();
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    virt_addr = ~virt_addr;
    table_word = ~table_word;
  endtask
endmodule

//--- test/tb.sv
// Self-checking bench for the address front end, 8K page option, 41-bit physical width.
// Assumes the core request model drives the inputs and answers come one cycle later.
`timescale 1ns/1ps
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin n_mismatch++; \
  $display("FAIL %0t: got %h expected %h", $time, g, x); end end
module tb
  import va_decode_pkg::*;
;
  typedef struct packed {region_t rg; logic [4:0] fl; logic nl; logic [63:0] pa; logic [63:0] idx;} exp_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid, user_mode, firmware_mode, firmware_fetch_unmapped, req_ready, rsp_valid;
  logic [63:0] virt_addr, table_word, phys_addr;
  access_t access;
  region_t region;
  logic [1:0] space_type;
  logic access_violation, translation_not_valid, fault_on_read, fault_on_write, fault_on_execute, needs_lookup;
  logic [15:0] level_index_0, level_index_1, level_index_2, page_offset_field;
  exp_t exp_q[$];
  exp_t e;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [63:0] va;
  logic fetch_pick;
  always #2 clk = ~clk;
  core_req_model core_req_model_i (.clk, .req_valid, .virt_addr, .access, .user_mode, .firmware_mode,
    .firmware_fetch_unmapped, .table_word);
  va_segment_decode #(.PAGE_OPTION(PAGE_8K), .PA_IMPL_BITS(41)) va_segment_decode_i (.clk, .rst, .req_valid,
    .virt_addr, .access, .user_mode, .firmware_mode, .firmware_fetch_unmapped, .table_word, .req_ready,
    .rsp_valid, .region, .phys_addr, .space_type, .access_violation, .translation_not_valid, .fault_on_read,
    .fault_on_write, .fault_on_execute, .needs_lookup, .level_index_0, .level_index_1, .level_index_2,
    .page_offset_field);
  ////////////////////////////////////////////////////////////////////////////
  // Expected answer for 43-bit virtual and 41-bit physical addresses
  function automatic exp_t model(logic [63:0] a, access_t k, logic um, logic [1:0] fw, logic [63:0] tw);
    exp_t r;
    logic rd;
    logic unmapped;
    r = '0;
    rd = (k != ACC_STORE);
    unmapped = (fw == 2'h3) && (k == ACC_FETCH);
    r.idx = {6'h0, a[42:33], 6'h0, a[32:23], 6'h0, a[22:13], 3'h0, a[12:0]};
    r.rg = REGION_NONE;
    if (a[63:42] != {22{a[42]}})
      r.fl = 5'h10;
    else
    begin
      r.rg = a[42] ? (a[41] ? REGION_HIGH : REGION_DIRECT) : REGION_LOW;
      r.nl = !unmapped && (r.rg != REGION_DIRECT);
      if (r.nl)
        r.pa = {23'h0, tw[59:32], a[12:0]};
      else
        r.pa = {23'h0, a[40:0]};
      if (unmapped)
        r.fl = 5'h0;
      else if (r.rg == REGION_DIRECT)
        r.fl = um ? 5'h10 : 5'h0;
      else if (!(rd ? tw[um ? 9 : 8] : tw[um ? 13 : 12]))
        r.fl = 5'h10;
      else if (!tw[0])
        r.fl = 5'h08;
      else
        r.fl = {2'h0, k == ACC_LOAD && tw[1], !rd && tw[2], k == ACC_FETCH && tw[3]};
      if (r.fl[4])
        r.pa = 64'h0;
    end
    return r;
  endfunction
  task automatic go(logic [63:0] a, access_t k, logic um, logic [1:0] fw, logic [63:0] tw);
    exp_q.push_back(model(a, k, um, fw, tw));
    core_req_model_i.send(a, k, um, fw, tw);
  endtask
  task automatic complete_run();
    $display("Counts: %0d comparisons, %0d mismatches", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Answers are looked at in the one cycle that rsp_valid stands
  always @(negedge clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
      `CHK(region, e.rg)
      `CHK({access_violation, translation_not_valid, fault_on_read, fault_on_write, fault_on_execute}, e.fl)
      `CHK(phys_addr, e.pa)
      if (!e.fl[4])
        `CHK(space_type, e.pa[40:39])
      `CHK({level_index_2, level_index_1, level_index_0, page_offset_field}, e.idx)
      `CHK(needs_lookup, e.nl)
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(99247));
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK({req_ready, rsp_valid, region, access_violation, phys_addr}, {2'b10, REGION_NONE, 1'b0, 64'h0})
    $display("Test reset done");
    for (int i = 0; i < 12; i++)
    begin
      case (i % 6)
        0: va = 64'h3ff_ffff_ffff;
        1: va = 64'h400_0000_0000;
        2: va = 64'hffff_fc00_0000_0000;
        3: va = 64'hffff_fbff_ffff_ffff;
        4: va = 64'h8000_0000_0000_0000;
        default: va = 64'h200_0000_0000;
      endcase
      go(va, ACC_LOAD, 1'(i / 6), 2'h0, 64'h0000_0001_0000_3301);
    end
    $display("Test range edges done");
    for (int i = 0; i < 6; i++)
      go(64'hffff_fc12_3456_789a, access_t'(i % 3), 1'(i / 3), 2'h0, 64'h0);
    $display("Test direct region done");
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 3; k++)
        for (int b = 0; b < 64; b++)
          go(m ? 64'hffff_fe01_2345_6789 : 64'h0123_4567_89ab, access_t'(k), m[0], 2'h0,
            {32'h0abc_1234, 18'h0, b[5:4], 2'h0, b[3:2], 4'h0, b[1], b[1], b[1] & (k != 2), b[0]});
    $display("Test protection done");
    go(64'h0123_4567_89ab, ACC_FETCH, 1'b1, 2'h3, 64'h0);
    go(64'h0123_4567_89ab, ACC_LOAD, 1'b1, 2'h3, 64'h0);
    go(64'h0123_4567_89ab, ACC_FETCH, 1'b1, 2'h1, 64'h0);
    go(64'h0123_4567_89ab, ACC_FETCH, 1'b0, 2'h2, 64'h0);
    go(64'hffff_fc12_3456_789a, ACC_FETCH, 1'b1, 2'h3, 64'h0);
    $display("Test firmware fetch done");
    for (int i = 0; i < 300; i++)
    begin
      va = {$urandom, $urandom};
      if (i % 8 != 0)
        va[63:43] = {21{va[42]}};
      fetch_pick = ($urandom % 3 == 2);
      go(va, fetch_pick ? ACC_FETCH : access_t'($urandom % 2), 1'($urandom % 2), 2'($urandom % 4),
        {$urandom, $urandom} & (fetch_pick ? ~64'h2 : ~64'h0));
    end
    core_req_model_i.idle();
    repeat (3) @(posedge clk);
    `CHK(exp_q.size(), 0)
    $display("Test random traffic done");
    complete_run();
  end
endmodule
